// ===== include/acsp_map.vh
`ifndef ACSP_MAP_VH
`define ACSP_MAP_VH

// ****************************************************************
// field and word geometry, counted in serial bit clock periods
// ****************************************************************
`define ACSP_FIELD64_LAST  5'h1f
`define ACSP_FIELD32_LAST  5'h0f
`define ACSP_WORD_LONG     5'h12
`define ACSP_WORD_SHORT    5'h10
`define ACSP_SAMPLE_W      18

// ****************************************************************
// master clock cycles per bit clock half period, as divider taps
// ****************************************************************
`define ACSP_DIV64_TAP     1
`define ACSP_DIV32_TAP     2

// ****************************************************************
// reset values
// ****************************************************************
`define ACSP_CHAN_RESET    1'b1
`define ACSP_POS_RESET     5'h00

`endif

// ===== verilog/acsp_bit_launch.v
`timescale 1ns/1ps

// ****************************************************************
// serial data launcher: msb from a falling master clock edge,
// every later bit from a rising edge
// ****************************************************************
module acsp_bit_launch (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_b_i,
  // word control, one-cycle pulses on the bit clock falling tick
  input  wire        load_i,
  input  wire        shift_i,
  input  wire [17:0] word_i,
  input  wire [4:0]  len_i,
  // serial data pin
  output wire        data_o
);

  reg [17:0] shreg_r;
  reg [4:0]  remain_r;
  reg        go_r;
  reg        go_msb_r;
  reg        next_val_r;
  reg        data_pos_r;
  reg        data_neg_r;
  reg        neg_sel_r;

  // a tick at edge t is launched at edge t+1; the msb copy leaves half a cycle earlier
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shreg_r    <= 18'h00000;
      remain_r   <= 5'h00;
      go_r       <= 1'b0;
      go_msb_r   <= 1'b0;
      next_val_r <= 1'b0;
      data_pos_r <= 1'b0;
    end else begin
      go_r     <= load_i | shift_i;
      go_msb_r <= load_i;
      if (load_i) begin
        next_val_r <= word_i[17];
        shreg_r    <= {word_i[16:0], 1'b0};
        remain_r   <= len_i - 5'h01;
      end else if (shift_i) begin
        // line idles low once the word is out
        next_val_r <= (remain_r != 5'h00) ? shreg_r[17] : 1'b0;
        shreg_r    <= {shreg_r[16:0], 1'b0};
        if (remain_r != 5'h00) begin
          remain_r <= remain_r - 5'h01;
        end
      end
      if (go_r) begin
        data_pos_r <= next_val_r;
      end
    end
  end

  always @(negedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_neg_r <= 1'b0;
      neg_sel_r  <= 1'b0;
    end else begin
      data_neg_r <= next_val_r;
      neg_sel_r  <= go_msb_r;
    end
  end

  // both flops hold the msb when the select falls back, so no glitch
  assign data_o = neg_sel_r ? data_neg_r : data_pos_r;

endmodule // acsp_bit_launch

// ===== verilog/acsp_serial_port.v
`timescale 1ns/1ps
`include "acsp_map.vh"

module acsp_serial_port (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_b_i,
  // static mode pins
  input  wire        frame64_i,
  input  wire        mode_s0_i,
  input  wire        mode_s1_i,
  input  wire        word18_i,
  // converter samples, same clock domain
  input  wire [17:0] sample_left_i,
  input  wire [17:0] sample_right_i,
  // serial bit clock pin
  input  wire        serial_bit_clock_i,
  output reg         serial_bit_clock_o,
  output reg         serial_bit_clock_oe_o,
  // channel select pin
  input  wire        channel_select_i,
  output reg         channel_select_o,
  output reg         channel_select_oe_o,
  // word strobe pin
  input  wire        word_strobe_i,
  output reg         word_strobe_o,
  output reg         word_strobe_oe_o,
  // serial data pin
  output wire        data_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function [4:0] field_last;
    input f64;
    begin
      field_last = f64 ? `ACSP_FIELD64_LAST : `ACSP_FIELD32_LAST;
    end
  endfunction

  function [4:0] word_len;
    input f64;
    input w18;
    begin
      word_len = (f64 && w18) ? `ACSP_WORD_LONG : `ACSP_WORD_SHORT;
    end
  endfunction

  // latest start keeps the word right justified in its field
  function [4:0] start_limit;
    input f64;
    input w18;
    begin
      start_limit = f64 ? (field_last(f64) - word_len(f64, w18) + 5'h01) : 5'h00;
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [3:0] mode_m_r;
  reg [3:0] mode_r;
  reg       ws_m_r;
  reg       ws_s_r;
  reg       bck_m_r;
  reg       bck_s_r;
  reg       lr_m_r;
  reg       lr_s_r;
  reg       bck_h_r;
  reg       mode_ok_m_r;
  reg       mode_ok_r;

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_m_r <= 4'h0;
      mode_r   <= 4'h0;
      ws_m_r   <= 1'b0;
      ws_s_r   <= 1'b0;
      bck_h_r  <= 1'b0;
      mode_ok_m_r <= 1'b0;
      mode_ok_r   <= 1'b0;
    end else begin
      mode_m_r <= {word18_i, mode_s1_i, mode_s0_i, frame64_i};
      mode_r   <= mode_m_r;
      // pin drivers stay off until the synced mode is real, else a slave drives for two cycles
      mode_ok_m_r <= 1'b1;
      mode_ok_r   <= mode_ok_m_r;
      ws_m_r   <= word_strobe_i;
      ws_s_r   <= ws_m_r;
      bck_h_r  <= bck_s_r;
    end
  end

  // bit clock and channel select share the falling edge sample
  always @(negedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bck_m_r <= 1'b0;
      bck_s_r <= 1'b0;
      lr_m_r  <= `ACSP_CHAN_RESET;
      lr_s_r  <= `ACSP_CHAN_RESET;
    end else begin
      bck_m_r <= serial_bit_clock_i;
      bck_s_r <= bck_m_r;
      lr_m_r  <= channel_select_i;
      lr_s_r  <= lr_m_r;
    end
  end

  wire f64       = mode_r[0];
  wire s0        = mode_r[1];
  wire s1        = mode_r[2];
  wire w18       = mode_r[3];
  wire is_master = ~s1;
  wire ws_out    = is_master & ~s0;
  wire ws_in     = s0 & f64;

  // ****************************************************************
  // master divider: no dependence on any receiver clock
  // ****************************************************************
  reg  [2:0] div_r;
  reg        mbck_r;
  wire       mbck_nxt = f64 ? div_r[`ACSP_DIV64_TAP] : div_r[`ACSP_DIV32_TAP];
  wire       m_fall   = mbck_r & ~mbck_nxt;
  wire       s_fall   = bck_h_r & ~bck_s_r;
  wire       fall_tick = is_master ? m_fall : s_fall;

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_r  <= 3'h0;
      mbck_r <= 1'b0;
    end else begin
      div_r  <= div_r + 3'h1;
      mbck_r <= mbck_nxt;
    end
  end

  // ****************************************************************
  // field tracking and word start
  // ****************************************************************
  reg  [4:0] pos_r;
  reg        channel_select_r;
  reg        started_r;
  reg        wsq_r;
  reg        first_r;
  wire [4:0] last    = field_last(f64);
  wire [4:0] limit   = start_limit(f64, w18);
  // slave field boundary is a channel select change seen with a bit clock fall
  wire       fstart  = is_master ? ((pos_r == last) | first_r) : (lr_s_r != channel_select_r);
  // the first master tick opens the left field instead of toggling away from it
  wire       channel_select_nx = fstart ? (is_master ? (first_r ? channel_select_r : ~channel_select_r) : lr_s_r) : channel_select_r;
  wire [4:0] pos_nx  = fstart ? 5'h00 : ((pos_r == last) ? last : pos_r + 5'h01);
  wire       busy    = started_r & ~fstart;
  reg        start_c;

  always @* begin
    start_c = 1'b0;
    if (fall_tick && !busy) begin
      if (!f64) begin
        start_c = (pos_nx == 5'h00);
      end else if (ws_in) begin
        start_c = ((pos_nx != 5'h00) && ws_s_r) || (pos_nx == limit);
      end else begin
        start_c = (pos_nx == limit);
      end
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_r     <= `ACSP_POS_RESET;
      channel_select_r    <= `ACSP_CHAN_RESET;
      started_r <= 1'b0;
      wsq_r     <= 1'b0;
      first_r   <= 1'b1;
    end else if (fall_tick) begin
      first_r   <= 1'b0;
      pos_r     <= pos_nx;
      channel_select_r    <= channel_select_nx;
      started_r <= busy | start_c;
      // strobe rises one bit ahead of the msb period
      wsq_r     <= f64 && (pos_nx == limit - 5'h01);
    end
  end

  // ****************************************************************
  // pin outputs, all launched from rising edges
  // ****************************************************************
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_bit_clock_o    <= 1'b0;
      serial_bit_clock_oe_o <= 1'b0;
      channel_select_o      <= `ACSP_CHAN_RESET;
      channel_select_oe_o   <= 1'b0;
      word_strobe_o         <= 1'b0;
      word_strobe_oe_o      <= 1'b0;
    end else begin
      serial_bit_clock_o    <= mbck_r;
      serial_bit_clock_oe_o <= is_master & mode_ok_r;
      channel_select_o      <= channel_select_r;
      channel_select_oe_o   <= is_master & mode_ok_r;
      // short frames hold the strobe high in its output mode
      word_strobe_o         <= mode_ok_r & (f64 ? wsq_r : 1'b1);
      word_strobe_oe_o      <= ws_out & mode_ok_r;
    end
  end

  // ****************************************************************
  // serial data
  // ****************************************************************
  wire [17:0] word_sel = channel_select_nx ? sample_left_i : sample_right_i;

  acsp_bit_launch u_launch (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .load_i    (start_c),
    .shift_i   (fall_tick & ~start_c),
    .word_i    (word_sel),
    .len_i     (word_len(f64, w18)),
    .data_o    (data_o)
  );

endmodule // acsp_serial_port

// ===== bench/acsp_port_monitor.sv
`timescale 1ns/1ps
module acsp_port_monitor (
  // clock, reset and mode pins
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire frame64_i,
  input wire mode_s0_i,
  input wire mode_s1_i,
  // port outputs
  input wire serial_bit_clock_o,
  input wire serial_bit_clock_oe_o,
  input wire channel_select_o,
  input wire channel_select_oe_o,
  input wire word_strobe_o,
  input wire word_strobe_oe_o,
  input wire data_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  wire mst = !mode_s1_i;
  // mode pins pass two sync stages, so enables are judged from the third edge
  bck_oe_mode_a: assert property ($past(rst_b_i, 3) |-> serial_bit_clock_oe_o == mst)
    else $error("bit clock enable wrong for mode");
  chan_oe_mode_a: assert property ($past(rst_b_i, 3) |-> channel_select_oe_o == mst)
    else $error("channel select enable wrong for mode");
  wso_oe_mode_a: assert property ($past(rst_b_i, 3) |->
    word_strobe_oe_o == (mst && !mode_s0_i))
    else $error("strobe enable wrong for mode");
  bck_half64_a: assert property (mst && frame64_i && $rose(serial_bit_clock_o) |->
    ##2 $fell(serial_bit_clock_o))
    else $error("bit clock high phase not two cycles");
  bck_half32_a: assert property (mst && !frame64_i && $rose(serial_bit_clock_o) |->
    ##4 $fell(serial_bit_clock_o))
    else $error("bit clock high phase not four cycles");
  // the msb leaves half a master cycle early, so it is seen one edge before the bit clock fall
  data_on_fall_a: assert property (mst && $changed(data_o) |->
    ##[0:1] $fell(serial_bit_clock_o))
    else $error("data moved away from a bit clock fall");
  chan_on_fall_a: assert property (mst && $changed(channel_select_o) |->
    $fell(serial_bit_clock_o))
    else $error("channel select moved away from a bit clock fall");
  wso_pulse_a: assert property (mst && !mode_s0_i && frame64_i && $rose(word_strobe_o) |->
    word_strobe_o [*4] ##1 !word_strobe_o)
    else $error("strobe pulse not one bit period");
  cover property (mst && $rose(word_strobe_o));
  cover property (mode_s1_i && $changed(data_o));
  cover property (mst && $fell(channel_select_o));
endmodule // acsp_port_monitor

bind acsp_serial_port acsp_port_monitor acsp_port_monitor_inst (.*);

// ===== bench/acsp_dsp_rx.sv
`timescale 1ns/1ps
module acsp_dsp_rx (
  // reset and serial pins
  input  wire        rst_b_i,
  input  wire        bck_i,
  input  wire        strobe_i,
  input  wire        chan_i,
  input  wire        data_i,
  // received word
  output reg  [23:0] word_o,
  output reg         left_o,
  output reg         done_o
);
  reg [23:0] sh_r;
  reg [4:0]  cnt_r;
  reg        st_r;
  reg        chan_r;
  // shifting on the bit clock rise equals the fall of its inverse
  always @(posedge bck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // strobe history starts high so a constant-high strobe never arms
      st_r <= 1'b1;
      cnt_r <= 5'h00;
      sh_r <= 24'h000000;
      word_o <= 24'h000000;
      chan_r <= 1'b0;
      left_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      st_r <= strobe_i;
      if (cnt_r != 5'h00) begin
        sh_r <= {sh_r[22:0], data_i};
        cnt_r <= cnt_r - 5'h01;
        if (cnt_r == 5'h01) begin
          word_o <= {sh_r[22:0], data_i};
          left_o <= chan_r;
          done_o <= ~done_o;
        end
      end else if (strobe_i && !st_r) begin
        cnt_r <= 5'h18;
        chan_r <= chan_i;
      end
    end
  end
endmodule // acsp_dsp_rx

// ===== bench/adc_serial_port_clock_sync_test.sv
`timescale 1ns/1ps
module adc_serial_port_clock_sync_test;
  reg         clk_sys_i = 1'b0;
  reg         rst_b_i = 1'b0;
  reg         f64 = 1'b1, s0 = 1'b0, s1 = 1'b0, w18 = 1'b1;
  reg         bck_tb = 1'b0, lr_tb = 1'b0, ws_tb = 1'b0;
  reg  [17:0] sl = 18'h2a5c3, sr = 18'h1d3a6;
  wire        bck_o, bck_oe, lr_o, lr_oe, ws_o, ws_oe, dat, rx_done, rx_left;
  wire [23:0] rx_word;
  wire        serial_bit_clock = bck_oe ? bck_o : bck_tb;
  wire        lr = lr_oe ? lr_o : lr_tb;
  wire        ws = ws_oe ? ws_o : ws_tb;
  integer     fails = 0, cmp_count = 0;
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  acsp_serial_port acsp_serial_port_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .frame64_i(f64), .mode_s0_i(s0), .mode_s1_i(s1), .word18_i(w18), .sample_left_i(sl),
    .sample_right_i(sr), .serial_bit_clock_i(serial_bit_clock), .serial_bit_clock_o(bck_o),
    .serial_bit_clock_oe_o(bck_oe), .channel_select_i(lr), .channel_select_o(lr_o),
    .channel_select_oe_o(lr_oe), .word_strobe_i(ws), .word_strobe_o(ws_o),
    .word_strobe_oe_o(ws_oe), .data_o(dat));
  // one converter, as port master or as slave to the bench link, feeding a receiver
  acsp_dsp_rx acsp_dsp_rx_inst (.rst_b_i(rst_b_i), .bck_i(serial_bit_clock), .strobe_i(ws), .chan_i(lr),
    .data_i(dat), .word_o(rx_word), .left_o(rx_left), .done_o(rx_done));
  task check(input [23:0] seen, input [23:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // mode pins only change while reset is held
  task restart(input a, input b, input c, input d);
    begin
      @(negedge clk_sys_i);
      rst_b_i = 1'b0;
      f64 = a;
      s0 = b;
      s1 = c;
      w18 = d;
      repeat (3) @(negedge clk_sys_i);
      rst_b_i = 1'b1;
    end
  endtask
  task rx_check(input wl, input [1:0] want);
    reg         d;
    reg  [17:0] s;
    integer     n;
    begin
      d = rx_done;
      for (n = 0; n < 4000 && rx_done === d; n = n + 1) @(negedge clk_sys_i);
      check({23'h0, rx_done !== d}, 24'h000001);
      s = rx_left ? sl : sr;
      check(rx_word, wl ? {s, 6'h00} : {s[17:2], 8'h00});
      if (want != 2'h2) check({23'h0, rx_left}, {23'h0, want[0]});
    end
  endtask
  // link clock of 200 ns runs only inside frames; low 5 cycles, high 3
  task drive_link;
    integer f, b, c;
    begin
      for (f = 0; f < 4; f = f + 1)
        for (b = 0; b < 32; b = b + 1)
          for (c = 0; c < 8; c = c + 1) begin
            @(negedge clk_sys_i);
            bck_tb <= (c >= 5);
            lr_tb <= f[0];
            ws_tb <= (b == 3 && c >= 2) || (b == 4 && c < 3);
          end
      @(negedge clk_sys_i);
      bck_tb <= 1'b0;
      ws_tb <= 1'b0;
    end
  endtask
  task test_master64(input wl);
    begin
      restart(1'b1, 1'b0, 1'b0, wl);
      rx_check(wl, 2'h1);
      rx_check(wl, 2'h0);
    end
  endtask
  // strobe stays high here, so the bench samples the first word itself on bit clock rises
  task test_master32;
    reg [15:0] w;
    integer    n;
    begin
      restart(1'b0, 1'b0, 1'b0, 1'b1);
      @(negedge bck_o);
      for (n = 0; n < 16; n = n + 1) begin
        @(posedge bck_o);
        @(negedge clk_sys_i);
        w = {w[14:0], dat};
        if (n == 0) check({23'h0, lr_o}, 24'h000001);
      end
      check({8'h00, w}, {8'h00, sl[17:2]});
      check({21'h0, bck_oe, lr_oe, ws_o}, 24'h000007);
    end
  endtask
  task test_slave64;
    begin
      restart(1'b1, 1'b1, 1'b1, 1'b1);
      fork
        drive_link;
        repeat (4) rx_check(1'b1, 2'h2);
      join
      check({22'h0, bck_oe, lr_oe}, 24'h000000);
    end
  endtask
  initial begin
    #500000;
    fails = fails + 1;
    final_report;
  end
  initial begin
    test_master64(1'b1);
    test_master64(1'b0);
    test_master32;
    test_slave64;
    final_report;
  end
endmodule // adc_serial_port_clock_sync_test
